// file: hw/art_timer.sv
// auto-reload timer with AXI4-Lite register slave
//
// Behaviour
// - reset clears mode control: timer off, interrupt enables off, auto-reload mode.
// - writing one to load bit loads reload value, clears prescaler; reads zero.
// - count enable set lets timer count; clear freezes prescaler and counter.
// - output enable drives pwm waveform on output pin; clear holds pin low.
// - edge interrupt request equals edge enable and edge flag.
// - match interrupt request equals match enable and match flag.
// - wrap interrupt request equals wrap enable and wrap flag.
// - mode bits: auto-reload, capture, capture with reset, load on edge.
// - flag register holds three flags, upper bits zero; writing one keeps flag.
// - every active input edge sets edge flag; writing zero or reset clears it.
// - counter equal to compare sets match flag; writing zero clears it.
// - counter wrap from FF sets wrap flag; writing zero clears it.
// - prescaler divides by two to the select value; select change keeps count.
// - edge enable turns detection on; polarity picks rising or falling edge.
// - clock select: internal, internal divided by three, input pin, reserved.
// - load port reads and writes the counter while it runs.
// - load port content is held during system reset, then follows the counter from zero.
// - reload register value is copied into counter on each overflow in auto-reload mode; other modes wrap the counter to zero.
// - compare register is compared continuously against the counter.
// - load port write copies value into counter at once, clears prescaler.
// - pwm output set on overflow, reset when counter reaches compare value.
// - capture modes copy counter on active edge; reset mode clears counter, prescaler.
// - load-on-edge mode copies reload value into counter on active edge.
module art_timer
  import art_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              timer_input_pin,
  output logic                   pwm_output_pin,
  output logic                   irq_edge,
  output logic                   irq_match,
  output logic                   irq_wrap
);

  // --------------------------------------------------------------------
  // functions
  // --------------------------------------------------------------------
  // low address bits are ignored: every register is one aligned word
  function automatic art_sel_t reg_sel(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-3:0] idx;
    idx = addr[ADDR_W-1:2];
    if (idx == (ADDR_W-2)'(IDX_MODE_CTRL)) begin
      reg_sel = SEL_MODE;
    end else if (idx == (ADDR_W-2)'(IDX_FLAG_STATUS)) begin
      reg_sel = SEL_FLAG;
    end else if (idx == (ADDR_W-2)'(IDX_CLK_EDGE)) begin
      reg_sel = SEL_CFG;
    end else if (idx == (ADDR_W-2)'(IDX_RELOAD)) begin
      reg_sel = SEL_RELOAD;
    end else if (idx == (ADDR_W-2)'(IDX_COMPARE)) begin
      reg_sel = SEL_CMP;
    end else if (idx == (ADDR_W-2)'(IDX_LOAD_PORT)) begin
      reg_sel = SEL_LOAD;
    end else begin
      reg_sel = SEL_NONE;
    end
  endfunction

  function automatic logic [6:0] psc_mask(input logic [2:0] sel);
    psc_mask = 7'((8'h01 << sel) - 8'h01);
  endfunction

  // --------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------
  logic              aw_have_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic              w_have_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;
  logic              wr_fire;
  logic              wr_en;
  art_sel_t          wr_sel;
  art_sel_t          rd_sel;
  logic [7:0]        wr_byte;
  logic [7:0]        rd_byte;

  art_mode_ctrl_t    mode_q;
  art_cfg_t          cfg_q;
  art_flags_t        flags_q;
  art_flags_t        flags_d;
  logic [7:0]        reload_q;
  logic [7:0]        compare_q;
  logic [7:0]        load_q;
  logic [7:0]        cnt_q;
  logic [7:0]        cnt_d;
  logic [6:0]        psc_q;
  logic [6:0]        psc_d;
  logic [6:0]        mask;
  logic [1:0]        div3_q;
  logic              pin_prev_q;
  logic              eq_prev_q;
  logic              pwm_q;
  logic              pin_out_q;

  logic              mode_wr;
  logic              flag_wr;
  logic              cfg_wr;
  logic              reload_wr;
  logic              compare_wr;
  logic              load_wr;
  logic              load_bit_wr;
  logic              active_edge;
  logic              src_tick;
  logic              cnt_en;
  logic              psc_tick;
  logic              capture;
  logic              capt_clr;
  logic              ext_load;
  logic              any_load;
  logic              wrap_evt;
  logic              match_evt;
  logic              eq;

  // --------------------------------------------------------------------
  // bus slave: write channels
  // --------------------------------------------------------------------
  // address and data are caught independently; the write acts once both are held
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready  = !w_have_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign wr_fire       = aw_have_q && w_have_q && !bvalid_q;
  assign wr_sel        = reg_sel(awaddr_q);
  assign wr_en         = wr_fire && wstrb_q[0];
  assign wr_byte       = wdata_q[7:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      awaddr_q  <= '0;
      w_have_q  <= 1'b0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_have_q <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q  <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // bus slave: read channels
  // --------------------------------------------------------------------
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign rd_sel        = reg_sel(s_axi_araddr);

  always_comb begin
    rd_byte = 8'h00;
    case (rd_sel)
      SEL_MODE:   rd_byte = {1'b0, mode_q};
      SEL_FLAG:   rd_byte = {5'h00, flags_q};
      SEL_CFG:    rd_byte = cfg_q;
      SEL_RELOAD: rd_byte = reload_q;
      SEL_CMP:    rd_byte = compare_q;
      SEL_LOAD:   rd_byte = load_q;
      default:    rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= {24'h00_0000, rd_byte};
      rresp_q  <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // register strobes
  // --------------------------------------------------------------------
  assign mode_wr     = wr_en && (wr_sel == SEL_MODE);
  assign flag_wr     = wr_en && (wr_sel == SEL_FLAG);
  assign cfg_wr      = wr_en && (wr_sel == SEL_CFG);
  assign reload_wr   = wr_en && (wr_sel == SEL_RELOAD);
  assign compare_wr  = wr_en && (wr_sel == SEL_CMP);
  assign load_wr     = wr_en && (wr_sel == SEL_LOAD);
  assign load_bit_wr = mode_wr && wr_byte[LOAD_BIT_POS];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= art_mode_ctrl_t'(MODE_CTRL_RST);
    end else if (mode_wr) begin
      mode_q <= art_mode_ctrl_t'(wr_byte[6:0]);
    end
  end

  // the reserved bit is dropped so it always reads zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= art_cfg_t'(CLK_EDGE_RST);
    end else if (cfg_wr) begin
      cfg_q <= art_cfg_t'(wr_byte & CLK_EDGE_WMASK);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_q <= COMPARE_RST;
    end else if (compare_wr) begin
      compare_q <= wr_byte;
    end
  end

  // a capture beats a software write landing in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reload_q <= RELOAD_RST;
    end else if (capture) begin
      reload_q <= cnt_q;
    end else if (reload_wr) begin
      reload_q <= wr_byte;
    end
  end

  // no reset: the port holds its value while reset is low, then follows the counter again from zero
  always_ff @(posedge aclk) begin
    if (aresetn) begin
      load_q <= cnt_d;
    end
  end

  // --------------------------------------------------------------------
  // clock source and edge detection
  // --------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div3_q     <= 2'h0;
      // tracking the pin in reset avoids a false edge at release
      pin_prev_q <= timer_input_pin;
    end else begin
      div3_q     <= (div3_q == DIV3_LAST) ? 2'h0 : div3_q + 2'h1;
      pin_prev_q <= timer_input_pin;
    end
  end

  assign active_edge = cfg_q.edge_control[EDGE_EN_POS] &&
                       (cfg_q.edge_control[EDGE_POL_POS] ?
                        (pin_prev_q && !timer_input_pin) :
                        (!pin_prev_q && timer_input_pin));

  always_comb begin
    src_tick = 1'b0;
    case (cfg_q.clock_select)
      CLK_INTERNAL: src_tick = 1'b1;
      CLK_DIV3:     src_tick = (div3_q == DIV3_LAST);
      CLK_PIN:      src_tick = !pin_prev_q && timer_input_pin;
      default:      src_tick = 1'b0;
    endcase
  end

  // --------------------------------------------------------------------
  // prescaler and counter
  // --------------------------------------------------------------------
  // select only widens the mask, the count itself is never touched by it
  assign mask     = psc_mask(cfg_q.prescale_select);
  assign cnt_en   = mode_q.count_enable && src_tick;
  assign psc_tick = cnt_en && ((psc_q & mask) == mask);
  assign capture  = active_edge && ((mode_q.mode_select == MODE_CAPTURE) ||
                                    (mode_q.mode_select == MODE_CAPTURE_RST));
  assign capt_clr = active_edge && (mode_q.mode_select == MODE_CAPTURE_RST);
  assign ext_load = active_edge && (mode_q.mode_select == MODE_EXT_LOAD);
  assign any_load = load_bit_wr || load_wr || capt_clr || ext_load;
  assign wrap_evt = psc_tick && !any_load && (cnt_q == COUNTER_MAX);

  always_comb begin
    cnt_d = cnt_q;
    psc_d = psc_q;
    if (load_bit_wr) begin
      cnt_d = reload_q;
      psc_d = PRESCALE_RST;
    end else if (load_wr) begin
      cnt_d = wr_byte;
      psc_d = PRESCALE_RST;
    end else if (capt_clr) begin
      cnt_d = COUNTER_RST;
      psc_d = PRESCALE_RST;
    end else if (ext_load) begin
      cnt_d = reload_q;
      psc_d = PRESCALE_RST;
    end else if (cnt_en) begin
      psc_d = psc_q + 7'h01;
      if (wrap_evt) begin
        // reloading only in auto-reload mode keeps the others free running
        cnt_d = (mode_q.mode_select == MODE_AUTO_RELOAD) ?
                reload_q : COUNTER_RST;
      end else if (psc_tick) begin
        cnt_d = cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= COUNTER_RST;
      psc_q <= PRESCALE_RST;
    end else begin
      cnt_q <= cnt_d;
      psc_q <= psc_d;
    end
  end

  // --------------------------------------------------------------------
  // compare, flags and pwm
  // --------------------------------------------------------------------
  // the match is taken on arrival so a stopped counter sets the flag once
  assign eq        = (cnt_q == compare_q);
  assign match_evt = eq && !eq_prev_q;

  always_comb begin
    flags_d = flags_q;
    if (flag_wr) begin
      flags_d = flags_q & art_flags_t'(wr_byte[2:0]);
    end
    // events win over a clear in the same cycle
    if (active_edge) begin
      flags_d.edge_flag = 1'b1;
    end
    if (match_evt) begin
      flags_d.match_flag = 1'b1;
    end
    if (wrap_evt) begin
      flags_d.wrap_flag = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q   <= art_flags_t'(FLAGS_RST);
      eq_prev_q <= 1'b0;
    end else begin
      flags_q   <= flags_d;
      eq_prev_q <= eq;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_q     <= 1'b0;
      pin_out_q <= 1'b0;
    end else begin
      if (wrap_evt) begin
        pwm_q <= 1'b1;
      end else if (match_evt) begin
        pwm_q <= 1'b0;
      end
      pin_out_q <= mode_q.output_enable && pwm_q;
    end
  end

  assign pwm_output_pin = pin_out_q;
  assign irq_edge       = mode_q.edge_irq_enable && flags_q.edge_flag;
  assign irq_match      = mode_q.match_irq_enable && flags_q.match_flag;
  assign irq_wrap       = mode_q.wrap_irq_enable && flags_q.wrap_flag;

  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  mode_reset_a: assert property (
    !$past(aresetn) |-> (mode_q == art_mode_ctrl_t'(MODE_CTRL_RST)) && !irq_wrap)
    else $error("mode control not cleared by reset");

  load_bit_a: assert property (
    load_bit_wr |=> (cnt_q == $past(reload_q)) && (psc_q == PRESCALE_RST))
    else $error("load bit did not load counter");

  freeze_hold_a: assert property (
    (!mode_q.count_enable && !any_load) |=> $stable(cnt_q) && $stable(psc_q))
    else $error("counter moved while disabled");

  pwm_gate_a: assert property (
    !mode_q.output_enable |=> !pwm_output_pin)
    else $error("pwm pin driven while output disabled");

  edge_irq_a: assert property (
    (mode_q.edge_irq_enable && active_edge) |=> irq_edge)
    else $error("edge request missing");

  match_irq_a: assert property (
    !mode_q.match_irq_enable |-> !irq_match)
    else $error("match request not masked");

  flag_keep_a: assert property (
    (flag_wr && (wr_byte[2:0] == 3'h7) && !active_edge && !match_evt && !wrap_evt)
      |=> $stable(flags_q))
    else $error("writing one changed a flag");

  edge_flag_a: assert property (
    active_edge |=> flags_q.edge_flag)
    else $error("edge flag not set");

  match_flag_a: assert property (
    match_evt |=> flags_q.match_flag && (pwm_q == $past(wrap_evt)))
    else $error("match did not set flag or clear pwm");

  wrap_reload_a: assert property (
    (wrap_evt && (mode_q.mode_select == MODE_AUTO_RELOAD))
      |=> (cnt_q == $past(reload_q)) && flags_q.wrap_flag && pwm_q)
    else $error("overflow did not reload and flag");

  load_port_a: assert property (
    (load_wr && !load_bit_wr) |=> (cnt_q == $past(wr_byte)) && (psc_q == PRESCALE_RST))
    else $error("load port write did not load counter");

  capture_a: assert property (
    (capt_clr && !load_bit_wr && !load_wr) |=> (reload_q == $past(cnt_q)) && (cnt_q == 8'h00))
    else $error("capture with reset failed");

  count_step_a: assert property (
    (psc_tick && !any_load && (cnt_q != COUNTER_MAX)) |=> cnt_q == $past(cnt_q) + 8'h01)
    else $error("counter did not step on prescaler pulse");

endmodule // art_timer

// file: shared/art_pkg.sv
// constants, field layouts and carrier types of the auto-reload timer block
package art_pkg;

  // ----------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [7:0]  IDX_MODE_CTRL   = 8'hD5;
  localparam logic [7:0]  IDX_FLAG_STATUS = 8'hD6;
  localparam logic [7:0]  IDX_CLK_EDGE    = 8'hD7;
  localparam logic [7:0]  IDX_RELOAD      = 8'hD9;
  localparam logic [7:0]  IDX_COMPARE     = 8'hDA;
  localparam logic [7:0]  IDX_LOAD_PORT   = 8'hDB;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [6:0]  MODE_CTRL_RST   = 7'h00;
  localparam logic [2:0]  FLAGS_RST       = 3'h0;
  localparam logic [7:0]  CLK_EDGE_RST    = 8'h00;
  localparam logic [7:0]  RELOAD_RST      = 8'h00;
  localparam logic [7:0]  COMPARE_RST     = 8'h00;
  localparam logic [7:0]  COUNTER_RST     = 8'h00;
  localparam logic [6:0]  PRESCALE_RST    = 7'h00;

  // ----------------------------------------------------------------------
  // field positions and masks
  // ----------------------------------------------------------------------
  localparam int          LOAD_BIT_POS    = 7;
  localparam int          EDGE_EN_POS     = 0;
  localparam int          EDGE_POL_POS    = 1;
  localparam logic [7:0]  CLK_EDGE_WMASK  = 8'hEF;
  localparam logic [7:0]  COUNTER_MAX     = 8'hFF;
  localparam logic [1:0]  DIV3_LAST       = 2'h2;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // ----------------------------------------------------------------------
  // enumerations and carriers
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_AUTO_RELOAD = 2'h0,
    MODE_CAPTURE     = 2'h1,
    MODE_CAPTURE_RST = 2'h2,
    MODE_EXT_LOAD    = 2'h3
  } art_mode_t;

  typedef enum logic [1:0] {
    CLK_INTERNAL = 2'h0,
    CLK_DIV3     = 2'h1,
    CLK_PIN      = 2'h2,
    CLK_RESERVED = 2'h3
  } art_clk_t;

  typedef enum logic [2:0] {
    SEL_MODE, SEL_FLAG, SEL_CFG, SEL_RELOAD, SEL_CMP, SEL_LOAD, SEL_NONE
  } art_sel_t;

  typedef struct packed {
    logic      count_enable;
    logic      output_enable;
    logic      edge_irq_enable;
    logic      match_irq_enable;
    logic      wrap_irq_enable;
    art_mode_t mode_select;
  } art_mode_ctrl_t;

  typedef struct packed {
    logic [2:0] prescale_select;
    logic       reserved_bit;
    logic [1:0] edge_control;
    art_clk_t   clock_select;
  } art_cfg_t;

  typedef struct packed {
    logic edge_flag;
    logic match_flag;
    logic wrap_flag;
  } art_flags_t;

endpackage : art_pkg

// file: verification/art_pin_model.sv
// pin-side partner: drives the timer input pin and counts pwm pulses
module art_pin_model (
  input  wire logic aclk,
  input  wire logic pwm_output_pin,
  output logic      timer_input_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  int pwm_rises = 0;
  initial timer_input_pin = 1'b0;
  always @(posedge pwm_output_pin) pwm_rises++;
  // level moves just after an edge, so the design never samples it mid-change
  task automatic drive(input logic v);
    @(posedge aclk);
    timer_input_pin <= v;
  endtask
endmodule // art_pin_model

// file: verification/art_timer_tb.sv
// register-level bench of the auto-reload timer
module art_timer_tb
  import art_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic        awready, wready, bvalid, arready, rvalid, pin, pwm, irq_e, irq_m, irq_w;
  logic [1:0]  bresp, rresp;
  int          miscompares = 0;
  int          cmp_count = 0;

  art_timer dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .timer_input_pin(pin), .pwm_output_pin(pwm), .irq_edge(irq_e), .irq_match(irq_m),
    .irq_wrap(irq_w)
  );
  art_pin_model pin_u (.aclk(aclk), .pwm_output_pin(pwm), .timer_input_pin(pin));

  // ----------------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [11:0] ad(input logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction
  // leading edge keeps a release and the next raise out of one time step
  task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
    int n = 0;
    @(posedge aclk);
    awaddr <= ad(i);
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 40);
    bready <= 1'b0;
    chk(bresp, r);
    chk(n < 40, 1'b1);
  endtask
  task automatic rd(input logic [7:0] i, input logic [7:0] e, input logic [1:0] r = RESP_OKAY);
    int n = 0;
    @(posedge aclk);
    araddr <= ad(i);
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (!rvalid && n < 40);
    rready <= 1'b0;
    chk({rresp, rdata}, {r, 24'h0, e});
    chk(n < 40, 1'b1);
  endtask
  task automatic end_of_test;
    if (miscompares == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    forever #5 aclk = ~aclk;
  end
  initial begin
    #100000;
    miscompares++;
    end_of_test;
  end

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(IDX_MODE_CTRL, 8'h00);
    wr(IDX_RELOAD, 8'hF0);
    wr(IDX_COMPARE, 8'hF8);
    wr(IDX_MODE_CTRL, 8'h80);
    rd(IDX_MODE_CTRL, 8'h00);
    rd(IDX_LOAD_PORT, 8'hF0);
    wr(IDX_LOAD_PORT, 8'hFE);
    rd(IDX_LOAD_PORT, 8'hFE);
    wr(IDX_MODE_CTRL, 8'h44);
    repeat (20) @(posedge aclk);
    chk(irq_w, 1'b1);
    chk(pin_u.pwm_rises == 0, 1'b1);
    wr(IDX_MODE_CTRL, 8'h64);
    repeat (40) @(posedge aclk);
    wr(IDX_MODE_CTRL, 8'h04);
    chk(pin_u.pwm_rises > 1, 1'b1);
    rd(IDX_FLAG_STATUS, 8'h03);
    chk(irq_m, 1'b0);
    wr(IDX_FLAG_STATUS, 8'h06);
    rd(IDX_FLAG_STATUS, 8'h02);
    chk(irq_w, 1'b0);
    wr(IDX_FLAG_STATUS, 8'h00);
    rd(IDX_FLAG_STATUS, 8'h00);
    wr(IDX_CLK_EDGE, 8'h04);
    wr(IDX_LOAD_PORT, 8'h33);
    wr(IDX_MODE_CTRL, 8'h01);
    pin_u.drive(1'b1);
    repeat (4) @(posedge aclk);
    rd(IDX_RELOAD, 8'h33);
    rd(IDX_FLAG_STATUS, 8'h04);
    chk(irq_e, 1'b0);
    wr(IDX_MODE_CTRL, 8'h13);
    chk(irq_e, 1'b1);
    wr(IDX_LOAD_PORT, 8'h50);
    wr(IDX_CLK_EDGE, 8'h0C);
    pin_u.drive(1'b0);
    repeat (4) @(posedge aclk);
    rd(IDX_LOAD_PORT, 8'h33);
    wr(IDX_CLK_EDGE, 8'h40);
    wr(IDX_LOAD_PORT, 8'h10);
    wr(IDX_MODE_CTRL, 8'h40);
    repeat (16) @(posedge aclk);
    wr(IDX_MODE_CTRL, 8'h00);
    rd(IDX_LOAD_PORT, 8'h15);
    wr(IDX_CLK_EDGE, 8'h04);
    wr(IDX_LOAD_PORT, 8'h44);
    wr(IDX_MODE_CTRL, 8'h02);
    pin_u.drive(1'b1);
    repeat (4) @(posedge aclk);
    rd(IDX_RELOAD, 8'h44);
    rd(IDX_LOAD_PORT, 8'h00);
    wr(IDX_COMPARE, 8'h00);
    wr(IDX_MODE_CTRL, 8'h08);
    chk(irq_m, 1'b1);
    rd(IDX_FLAG_STATUS, 8'h06);
    wr(IDX_CLK_EDGE, 8'h02);
    wr(IDX_LOAD_PORT, 8'h20);
    wr(IDX_MODE_CTRL, 8'h40);
    pin_u.drive(1'b0);
    pin_u.drive(1'b1);
    pin_u.drive(1'b0);
    pin_u.drive(1'b1);
    repeat (2) @(posedge aclk);
    wr(IDX_MODE_CTRL, 8'h00);
    rd(IDX_LOAD_PORT, 8'h22);
    wr(8'hD8, 8'h00, RESP_SLVERR);
    rd(8'hD8, 8'h00, RESP_SLVERR);
    wr(IDX_MODE_CTRL, 8'h7C);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(IDX_MODE_CTRL, 8'h00);
    rd(IDX_FLAG_STATUS, 8'h02);
    end_of_test;
  end
endmodule // art_timer_tb
